// ---- bench/raeiq_board.sv ----
// Board-side model: reset supervisor and the interrupting device.
// Assumes the bench commands it on CLK edges; the pins follow at once.
`timescale 1ns/100ps
`default_nettype none

module raeiq_board (
    // Commands from the bench.
    input wire logic full_rst,
    input wire logic dbg_rst,
    input wire logic irq_on,
    // Pins toward the block, all active low.
    output logic rst_b,
    output logic trst_b,
    output logic ext_irq_a_n
);
    // A full reset pulls both lines; a debug reset spares the test port.
    assign rst_b = !(full_rst || dbg_rst);
    assign trst_b = !full_rst;
    // The device holds the request line low while it wants service.
    assign ext_irq_a_n = !irq_on;
endmodule

`default_nettype wire

// ---- bench/raeiq_top_bench.sv ----
// Self-checking bench for the reset and interrupt input conditioner.
// Assumes the board model drives the pins and a short hold count of 4.
`timescale 1ns/100ps
`default_nettype none

module raeiq_top_bench;
    localparam int HOLD = 4;
    logic clk = 1'h0;
    logic full_rst = 1'h1;
    logic dbg_rst = 1'h0;
    logic irq_on = 1'h0;
    logic rst_b, trst_b, ext_irq_a_n;
    raeiq_pkg::raeiq_mode_type mode = raeiq_pkg::RAEIQ_RUN;
    raeiq_pkg::raeiq_irq_cfg_type cfg = 2'h1;
    logic ack = 1'h0;
    logic we = 1'h0;
    raeiq_pkg::raeiq_pin_sel_type wr = 4'h0;
    logic core_rst_b, emu_rst_b, irq_req, wake_req;
    raeiq_pkg::raeiq_pin_sel_type pin_sel;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;

    raeiq_board board (.full_rst(full_rst), .dbg_rst(dbg_rst), .irq_on(irq_on),
        .rst_b(rst_b), .trst_b(trst_b), .ext_irq_a_n(ext_irq_a_n));
    raeiq_top #(.HOLD_CYCLES(HOLD)) DUT (.CLK(clk), .RST_B(rst_b), .TRST_B(trst_b),
        .EXT_IRQ_A_N(ext_irq_a_n), .MODE(mode), .IRQ_CFG(cfg), .IRQ_ACK(ack),
        .PIN_SEL_WR(wr), .PIN_SEL_WE(we), .CORE_RST_B(core_rst_b), .EMU_RST_B(emu_rst_b),
        .IRQ_REQ(irq_req), .WAKE_REQ(wake_req), .PIN_SEL(pin_sel));

    // Free-running 10 MHz clock.
    initial begin
        forever #50 clk = ~clk;
    end

    // Cut a hang short well beyond the 75 or so cycles the run needs.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // Drives land on the edge; looks wait for that edge's updates to settle.
    task automatic at(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic look(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Full reset held 20 cycles, then release after exactly HOLD+2 edges.
    task automatic full_reset();
        look(19);
        check({3'h0, core_rst_b}, 4'h0);
        check({3'h0, emu_rst_b}, 4'h0);
        check(pin_sel, 4'h0);
        at(1);
        full_rst <= 1'h0;
        look(HOLD + 1);
        check({3'h0, core_rst_b}, 4'h0);
        look(1);
        check({3'h0, core_rst_b}, 4'h1);
    endtask

    // Pins reassigned, then a debug reset must restore timer use but spare emulation.
    task automatic debug_reset();
        at(1);
        wr <= '{ch_zero_fn: raeiq_pkg::PIN_FN_SERIAL, ch_one_fn: raeiq_pkg::PIN_FN_GPIO};
        we <= 1'h1;
        at(1);
        we <= 1'h0;
        dbg_rst <= 1'h1;
        #1;
        check(pin_sel, {raeiq_pkg::PIN_FN_SERIAL, raeiq_pkg::PIN_FN_GPIO});
        look(3);
        check({3'h0, core_rst_b}, 4'h0);
        check({3'h0, emu_rst_b}, 4'h1);
        check(pin_sel, 4'h0);
        at(1);
        dbg_rst <= 1'h0;
        look(HOLD + 2);
        check({3'h0, core_rst_b}, 4'h1);
    endtask

    // Run mode: level, falling edge and disabled request.
    task automatic run_irq();
        at(1);
        irq_on <= 1'h1;
        look(2);
        check({3'h0, irq_req}, 4'h0);
        look(1);
        check({3'h0, irq_req}, 4'h1);
        at(1);
        irq_on <= 1'h0;
        look(3);
        check({3'h0, irq_req}, 4'h0);
        at(1);
        cfg <= '{sense: raeiq_pkg::SENSE_FALL, enable: 1'h1};
        irq_on <= 1'h1;
        look(3);
        check({3'h0, irq_req}, 4'h1);
        at(1);
        irq_on <= 1'h0;
        look(4);
        check({3'h0, irq_req}, 4'h1);
        at(1);
        ack <= 1'h1;
        at(1);
        ack <= 1'h0;
        look(1);
        check({3'h0, irq_req}, 4'h0);
        at(1);
        cfg <= '{sense: raeiq_pkg::SENSE_LEVEL, enable: 1'h0};
        irq_on <= 1'h1;
        look(4);
        check({3'h0, irq_req}, 4'h0);
        at(1);
        irq_on <= 1'h0;
        cfg <= 2'h1;
    endtask

    // Wait and stop: the pin raises wake before any clock edge can see it.
    task automatic low_power_wake();
        for (int i = 0; i < 2; i++) begin
            at(1);
            mode <= (i == 0) ? raeiq_pkg::RAEIQ_WAIT : raeiq_pkg::RAEIQ_STOP;
            at(1);
            irq_on <= 1'h1;
            #1;
            check({3'h0, wake_req}, 4'h1);
            at(1);
            irq_on <= 1'h0;
            at(1);
            ack <= 1'h1;
            at(1);
            ack <= 1'h0;
            #1;
            check({3'h0, wake_req}, 4'h0);
        end
        at(1);
        mode <= raeiq_pkg::RAEIQ_RUN;
    endtask

    task automatic complete_run();
        if (err_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        full_reset();
        debug_reset();
        run_irq();
        low_power_wake();
        complete_run();
    end
endmodule

`default_nettype wire

// ---- logic/raeiq_pkg.sv ----
// Package for the reset and external interrupt input conditioner.
// Assumes a single 10 MHz clock; shared by the one design module.
package raeiq_pkg;

    // Clock period in nanoseconds.
    localparam int CLK_PERIOD_NS = 100;

    // Default count of internal clocks before the internal reset is released.
    localparam int RESET_HOLD_CYCLES = 32;
    localparam int HOLD_CNT_W = 16;

    // Synchroniser depth for the interrupt request.
    localparam int SYNC_STAGES = 2;

    // Shared pin function codes for the two timer pins.
    localparam logic [1:0] PIN_FN_TIMER = 2'h0;
    localparam logic [1:0] PIN_FN_SERIAL = 2'h1;
    localparam logic [1:0] PIN_FN_GPIO = 2'h2;

    // Sensitivity codes.
    localparam logic SENSE_LEVEL = 1'h0;
    localparam logic SENSE_FALL = 1'h1;

    // Power modes that the core reports.
    typedef enum logic [1:0] {
        RAEIQ_RUN,
        RAEIQ_WAIT,
        RAEIQ_STOP,
        RAEIQ_DEBUG
    } raeiq_mode_type;

    // Reset sequencer states.
    typedef enum logic [1:0] {
        RAEIQ_HELD,
        RAEIQ_COUNT,
        RAEIQ_RELEASED
    } raeiq_rst_state_type;

    // Interrupt configuration carried together.
    typedef struct packed {
        logic sense;
        logic enable;
    } raeiq_irq_cfg_type;

    // Pin function selections of both timer pins.
    typedef struct packed {
        logic [1:0] ch_zero_fn;
        logic [1:0] ch_one_fn;
    } raeiq_pin_sel_type;

endpackage

// ---- logic/raeiq_top.sv ----
// Reset and external interrupt input conditioner.
// Assumes RST_B and the interrupt pin arrive sampled on CLK; the stop/wait
// capture path is a latch style set that the pin itself can raise.
//
// How it works
// - In stop or wait the interrupt low level is caught without needing a clock edge to detect it.
// - In every mode the service request takes the pin through a two stage synchroniser; only the wake capture uses it raw.
// - Software chooses level or falling edge sensitivity for the interrupt.
// - A low hardware reset puts and holds the controller in reset, except the wake request, which a low interrupt pin still sets.
// - The internal reset is released on a clock edge a fixed number of clocks after the pin rises.
// - Hardware reset alone leaves the test port and emulation reset untouched.
// - After reset the timer C channel zero function owns its shared pin.
// - After reset the timer C channel one function owns its shared pin.
`timescale 1ns/100ps
`default_nettype none

module raeiq_top #(
    parameter int HOLD_CYCLES = raeiq_pkg::RESET_HOLD_CYCLES
) (
    // Clock and hardware reset.
    input wire logic CLK,
    input wire logic RST_B,
    // Test port reset, active low.
    input wire logic TRST_B,
    // External interrupt pin, active low.
    input wire logic EXT_IRQ_A_N,
    // Power mode and software configuration.
    input wire raeiq_pkg::raeiq_mode_type MODE,
    input wire raeiq_pkg::raeiq_irq_cfg_type IRQ_CFG,
    input wire logic IRQ_ACK,
    input wire raeiq_pkg::raeiq_pin_sel_type PIN_SEL_WR,
    input wire logic PIN_SEL_WE,
    // Outputs.
    output logic CORE_RST_B,
    output logic EMU_RST_B,
    output logic IRQ_REQ,
    output logic WAKE_REQ,
    output var raeiq_pkg::raeiq_pin_sel_type PIN_SEL
);

    localparam logic [raeiq_pkg::HOLD_CNT_W-1:0] HOLD_LAST = raeiq_pkg::HOLD_CNT_W'(HOLD_CYCLES - 1);

    raeiq_pkg::raeiq_rst_state_type rst_state_reg;
    logic [raeiq_pkg::HOLD_CNT_W-1:0] hold_cnt_reg;
    logic [raeiq_pkg::SYNC_STAGES-1:0] irq_sync_reg;
    logic irq_prev_reg;
    logic irq_pend_reg;
    logic low_power;
    logic irq_low;
    logic fall_seen;

    // Stop and wait hold the raw-pin wake until acknowledged; other modes drop it at the first edge with the pin high.
    assign low_power = (MODE == raeiq_pkg::RAEIQ_STOP) || (MODE == raeiq_pkg::RAEIQ_WAIT);
    assign irq_low = ~irq_sync_reg[raeiq_pkg::SYNC_STAGES-1];
    assign fall_seen = irq_prev_reg & irq_low;

    // Reset sequencer: hold while the pin is low, then count before release.
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            rst_state_reg <= raeiq_pkg::RAEIQ_HELD;
            hold_cnt_reg <= '0;
        end else begin
            unique case (rst_state_reg)
                raeiq_pkg::RAEIQ_HELD: begin
                    rst_state_reg <= raeiq_pkg::RAEIQ_COUNT;
                    hold_cnt_reg <= '0;
                end
                raeiq_pkg::RAEIQ_COUNT: begin
                    if (hold_cnt_reg == HOLD_LAST) begin
                        rst_state_reg <= raeiq_pkg::RAEIQ_RELEASED;
                    end else begin
                        hold_cnt_reg <= hold_cnt_reg + 1'b1;
                    end
                end
                raeiq_pkg::RAEIQ_RELEASED: begin
                    rst_state_reg <= raeiq_pkg::RAEIQ_RELEASED;
                end
                default: begin
                    rst_state_reg <= raeiq_pkg::RAEIQ_HELD;
                end
            endcase
        end
    end

    // Core reset output; registered so it changes only on a clock edge.
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            CORE_RST_B <= 1'b0;
        end else begin
            CORE_RST_B <= (rst_state_reg == raeiq_pkg::RAEIQ_RELEASED);
        end
    end

    // Emulation reset follows the test port reset only, so a debugger keeps its state.
    always_ff @(posedge CLK) begin
        EMU_RST_B <= TRST_B;
    end

    // Two stage synchroniser; the first stage feeds only the second.
    always_ff @(posedge CLK) begin
        if (!CORE_RST_B) begin
            irq_sync_reg <= '1;
        end else begin
            irq_sync_reg <= {irq_sync_reg[raeiq_pkg::SYNC_STAGES-2:0], EXT_IRQ_A_N};
        end
    end

    // Previous synchronised level for falling edge detection; it resets to the idle high level.
    always_ff @(posedge CLK) begin
        if (!CORE_RST_B) begin
            irq_prev_reg <= 1'b1;
        end else begin
            irq_prev_reg <= ~irq_low;
        end
    end

    // Pending edge request; a new edge wins over an acknowledge.
    always_ff @(posedge CLK) begin
        if (!CORE_RST_B) begin
            irq_pend_reg <= 1'b0;
        end else if (IRQ_CFG.sense == raeiq_pkg::SENSE_FALL && fall_seen) begin
            irq_pend_reg <= 1'b1;
        end else if (IRQ_ACK) begin
            irq_pend_reg <= 1'b0;
        end
    end

    // Service request: level follows the pin, edge mode uses the pending flag.
    always_ff @(posedge CLK) begin
        if (!CORE_RST_B) begin
            IRQ_REQ <= 1'b0;
        end else if (IRQ_CFG.sense == raeiq_pkg::SENSE_LEVEL) begin
            IRQ_REQ <= IRQ_CFG.enable & irq_low;
        end else begin
            IRQ_REQ <= IRQ_CFG.enable & (irq_pend_reg | fall_seen);
        end
    end

    // Asynchronous wake capture in stop or wait; the pin sets it with no clock
    // edge, which is the only way out of stop when the clock is gated.
    always_ff @(posedge CLK or negedge EXT_IRQ_A_N) begin
        if (!EXT_IRQ_A_N) begin
            WAKE_REQ <= 1'b1;
        end else if (!CORE_RST_B || !low_power) begin
            WAKE_REQ <= 1'b0;
        end else if (IRQ_ACK) begin
            WAKE_REQ <= 1'b0;
        end
    end

    // Timer functions own both shared pins after reset; software may move them.
    always_ff @(posedge CLK) begin
        if (!CORE_RST_B) begin
            PIN_SEL.ch_zero_fn <= raeiq_pkg::PIN_FN_TIMER;
            PIN_SEL.ch_one_fn <= raeiq_pkg::PIN_FN_TIMER;
        end else if (PIN_SEL_WE) begin
            PIN_SEL <= PIN_SEL_WR;
        end
    end

    // Edges from the first one that sees the pin high through the one that raises the core reset.
    localparam logic [raeiq_pkg::HOLD_CNT_W-1:0] RELEASE_EDGES = raeiq_pkg::HOLD_CNT_W'(HOLD_CYCLES + 2);

    // Cycle counter watched by the release check; it saturates so a stuck reset cannot wrap it.
    logic [raeiq_pkg::HOLD_CNT_W-1:0] release_cnt_reg;
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            release_cnt_reg <= '0;
        end else if (!CORE_RST_B && release_cnt_reg != '1) begin
            release_cnt_reg <= release_cnt_reg + 1'b1;
        end
    end

    // A falling edge as the synchroniser output shows it.
    sequence seq_fall;
        irq_sync_reg[raeiq_pkg::SYNC_STAGES-1] ##1 !irq_sync_reg[raeiq_pkg::SYNC_STAGES-1];
    endsequence

    // An acknowledge in edge mode with no new edge arriving beside it.
    sequence seq_ack_only;
        IRQ_ACK && !fall_seen && IRQ_CFG.sense == raeiq_pkg::SENSE_FALL;
    endsequence

    // Edge mode with no new edge in this cycle.
    sequence seq_edge_quiet;
        !fall_seen && IRQ_CFG.sense == raeiq_pkg::SENSE_FALL;
    endsequence

    // An acknowledge in stop or wait while the pin is back high.
    sequence seq_wake_ack;
        EXT_IRQ_A_N && low_power && IRQ_ACK;
    endsequence

    chk_reset_hold: assert property (@(posedge CLK) !RST_B |=> !CORE_RST_B)
        else $error("core reset not held");
    chk_release_count: assert property (@(posedge CLK) disable iff (!RST_B)
        $rose(CORE_RST_B) |-> release_cnt_reg == RELEASE_EDGES)
        else $error("release count wrong");
    chk_emu_kept: assert property (@(posedge CLK) TRST_B |=> EMU_RST_B)
        else $error("emulation reset hit by core reset");
    chk_emu_follows: assert property (@(posedge CLK) !TRST_B |=> !EMU_RST_B)
        else $error("emulation reset missed test port reset");
    chk_sync_delay: assert property (@(posedge CLK) disable iff (!CORE_RST_B)
        $fell(EXT_IRQ_A_N) ##1 !EXT_IRQ_A_N |=> !irq_sync_reg[raeiq_pkg::SYNC_STAGES-1])
        else $error("sync depth wrong");
    chk_sync_early: assert property (@(posedge CLK) disable iff (!CORE_RST_B)
        $fell(EXT_IRQ_A_N) |=> irq_sync_reg[raeiq_pkg::SYNC_STAGES-1])
        else $error("synchroniser passed the pin too early");
    chk_level_req: assert property (@(posedge CLK) disable iff (!CORE_RST_B)
        IRQ_CFG.enable && IRQ_CFG.sense == raeiq_pkg::SENSE_LEVEL && irq_low |=> IRQ_REQ)
        else $error("level request missing");
    chk_edge_req: assert property (@(posedge CLK) disable iff (!CORE_RST_B)
        seq_fall ##0 (IRQ_CFG.enable && IRQ_CFG.sense == raeiq_pkg::SENSE_FALL) |=> IRQ_REQ)
        else $error("edge request missing");
    chk_ack_clears: assert property (@(posedge CLK) disable iff (!CORE_RST_B)
        seq_ack_only ##1 seq_edge_quiet |=> !IRQ_REQ)
        else $error("acknowledge did not clear edge request");
    chk_wake_async: assert property (@(posedge CLK)
        !EXT_IRQ_A_N |-> WAKE_REQ)
        else $error("wake not caught");
    chk_wake_clear: assert property (@(posedge CLK) disable iff (!CORE_RST_B)
        seq_wake_ack ##1 EXT_IRQ_A_N |-> !WAKE_REQ)
        else $error("wake not cleared by acknowledge");
    chk_pins_default: assert property (@(posedge CLK) $rose(CORE_RST_B) |->
        PIN_SEL.ch_zero_fn == raeiq_pkg::PIN_FN_TIMER && PIN_SEL.ch_one_fn == raeiq_pkg::PIN_FN_TIMER)
        else $error("timer pins not default");

endmodule

`default_nettype wire
